//--- rtci2c_sync.sv
// constants package and a two-flop level synchroniser for the rtc serial slave
package rtci2c_pkg;
  // ==========================================================
  // bus addressing
  localparam logic [7:0] DEV_ADDR_BYTE = 8'hd0;
  localparam int LOC_PTR_W = 3;
  localparam logic [LOC_PTR_W-1:0] PTR_RESET = 3'h0;
  localparam logic [LOC_PTR_W-1:0] PTR_STEP = 3'h1;
  // ==========================================================
  // bit counting within a byte
  localparam logic [3:0] CNT_FIRST = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WADDR, ST_WDATA, ST_RDATA} rtci2c_state_t;
endpackage

module rtci2c_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

//--- rtci2c_slave.sv
// serial two-wire slave access logic of the real-time clock
// ==========================================================
// Notes on behaviour
// - write-addressed byte after address loads pointer
// - repeated start with read bit transmits at pointer
// - read pointer advances on master ack only
// - acked read is followed by next location
// - reading continues until master nack or stop
// - plain read starts at retained pointer
// - first written byte becomes word address
// - data bytes stored, pointer advances on ack
// - ack address, word address, every data byte
// - supply fail deselects and blocks writes
// - answer only address bytes d0h and d1h after start
// - eight byte locations in fixed order
// - supply fail aborts, clears pointer, ignores bus
// - release data line after master nack
module rtci2c_slave
  import rtci2c_pkg::*;
(
  // system clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // serial link; scl clocks the link logic
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // supply monitor, below backup_switchover_threshold when high
  input wire logic pwr_fail,
  // location store, read side
  output logic [LOC_PTR_W-1:0] rd_addr,
  input wire logic [7:0] rd_data,
  // location store, write side
  output logic wr_valid,
  output logic [LOC_PTR_W-1:0] wr_addr,
  output logic [7:0] wr_data
);
  // ==========================================================
  // reset release and supply monitor (clk domain)
  logic rst_meta;
  logic rst_q;
  logic pf_s;
  logic link_rst_n;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta <= 1'b0;
      rst_q <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_q <= rst_meta;
    end
  end

  rtci2c_sync #(.W(1)) u_pf_sync (.clk(clk), .rst_n(rst_q), .d(pwr_fail), .q(pf_s));

  // link logic is held in reset while supply is out of tolerance
  always_ff @(posedge clk or negedge rst_q)
  begin
    if (!rst_q)
      link_rst_n <= 1'b0;
    else
      link_rst_n <= ~pf_s;
  end

  // ==========================================================
  // start and stop detection, clocked by the data line
  logic start_tog;
  logic stop_tog;
  logic next_start_tog;
  logic next_stop_tog;

  always_comb
  begin
    next_start_tog = scl ? ~start_tog : start_tog;
    next_stop_tog = scl ? ~stop_tog : stop_tog;
  end

  always_ff @(negedge sda_in or negedge link_rst_n)
  begin
    if (!link_rst_n)
      start_tog <= 1'b0;
    else
      start_tog <= next_start_tog;
  end

  always_ff @(posedge sda_in or negedge link_rst_n)
  begin
    if (!link_rst_n)
      stop_tog <= 1'b0;
    else
      stop_tog <= next_stop_tog;
  end

  // ==========================================================
  // link engine, sampled on rising scl
  rtci2c_state_t state;
  rtci2c_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] sh;
  logic [7:0] next_sh;
  logic [LOC_PTR_W-1:0] ptr;
  logic [LOC_PTR_W-1:0] next_ptr;
  logic start_seen;
  logic stop_seen;
  logic addr_hit;

  // toggles survive a supply-fail reset so the clk side sees no false edge
  logic fetch_tog;
  logic next_fetch_tog;
  logic wr_tog;
  logic next_wr_tog;
  logic [LOC_PTR_W-1:0] wr_addr_l;
  logic [LOC_PTR_W-1:0] next_wr_addr_l;
  logic [7:0] wr_data_l;
  logic [7:0] next_wr_data_l;

  assign addr_hit = (sh[7:1] == DEV_ADDR_BYTE[7:1]);

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_sh = sh;
    next_ptr = ptr;
    next_fetch_tog = fetch_tog;
    next_wr_tog = wr_tog;
    next_wr_addr_l = wr_addr_l;
    next_wr_data_l = wr_data_l;
    if (start_tog != start_seen)
    begin
      // first address bit arrives with the start's first clock
      next_state = ST_ADDR;
      next_cnt = CNT_FIRST;
      next_sh = {7'h00, sda_in};
    end
    else if (stop_tog != stop_seen)
      next_state = ST_IDLE;
    else
    begin
      case (state)
        ST_IDLE:
          next_state = ST_IDLE;
        ST_RDATA:
        begin
          if (cnt != CNT_ACK)
            next_cnt = cnt + CNT_FIRST;
          else if (!sda_in)
          begin
            // master acked: move on and prefetch the next location
            next_ptr = ptr + PTR_STEP;
            next_fetch_tog = ~fetch_tog;
            next_cnt = CNT_ZERO;
          end
          else
            next_state = ST_IDLE;
        end
        default:
        begin
          if (cnt != CNT_ACK)
          begin
            next_sh = {sh[6:0], sda_in};
            next_cnt = cnt + CNT_FIRST;
          end
          else
          begin
            next_cnt = CNT_ZERO;
            case (state)
              ST_ADDR:
              begin
                if (!addr_hit)
                  next_state = ST_IDLE;
                else if (sh[0])
                begin
                  next_state = ST_RDATA;
                  next_fetch_tog = ~fetch_tog;
                end
                else
                  next_state = ST_WADDR;
              end
              ST_WADDR:
              begin
                // upper word-address bits are ignored
                next_ptr = sh[LOC_PTR_W-1:0];
                next_state = ST_WDATA;
              end
              ST_WDATA:
              begin
                next_wr_addr_l = ptr;
                next_wr_data_l = sh;
                next_wr_tog = ~wr_tog;
                next_ptr = ptr + PTR_STEP;
              end
              default:
                next_state = ST_IDLE;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge scl or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      state <= ST_IDLE;
      cnt <= CNT_ZERO;
      sh <= BYTE_RESET;
      ptr <= PTR_RESET;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      sh <= next_sh;
      ptr <= next_ptr;
      start_seen <= start_tog;
      stop_seen <= stop_tog;
    end
  end

  always_ff @(posedge scl or negedge rst_q)
  begin
    if (!rst_q)
    begin
      fetch_tog <= 1'b0;
      wr_tog <= 1'b0;
      wr_addr_l <= PTR_RESET;
      wr_data_l <= BYTE_RESET;
    end
    else
    begin
      fetch_tog <= next_fetch_tog;
      wr_tog <= next_wr_tog;
      wr_addr_l <= next_wr_addr_l;
      wr_data_l <= next_wr_data_l;
    end
  end

  // ==========================================================
  // data line driver, updated on falling scl so sda only moves while scl is low, except when a supply-fail reset releases it
  logic [7:0] rd_byte;
  logic drive_low;
  logic next_drive_low;

  always_comb
  begin
    next_drive_low = 1'b0;
    if (state == ST_RDATA && cnt != CNT_ACK)
      next_drive_low = ~rd_byte[~cnt[2:0]];
    else if (cnt == CNT_ACK && (state == ST_WADDR || state == ST_WDATA))
      next_drive_low = 1'b1;
    else if (cnt == CNT_ACK && state == ST_ADDR && addr_hit)
      next_drive_low = 1'b1;
  end

  always_ff @(negedge scl or negedge link_rst_n)
  begin
    if (!link_rst_n)
      drive_low <= 1'b0;
    else
      drive_low <= next_drive_low;
  end

  assign sda_out = 1'b0;
  assign sda_oe = drive_low;

  // ==========================================================
  // clk side of the crossings
  // rd_byte is read by the link only after the scl high time, which must cover the four clk cycles from toggle to rd_byte
  logic fetch_s;
  logic fetch_d;
  logic wr_s;
  logic wr_d;
  logic rd_pend;
  logic next_rd_pend;
  logic [LOC_PTR_W-1:0] next_rd_addr;
  logic [7:0] next_rd_byte;
  logic next_wr_valid;
  logic [LOC_PTR_W-1:0] next_wr_addr;
  logic [7:0] next_wr_data;

  rtci2c_sync #(.W(1)) u_fetch_sync (.clk(clk), .rst_n(rst_q), .d(fetch_tog), .q(fetch_s));
  rtci2c_sync #(.W(1)) u_wr_sync (.clk(clk), .rst_n(rst_q), .d(wr_tog), .q(wr_s));

  always_comb
  begin
    next_rd_pend = 1'b0;
    next_rd_addr = rd_addr;
    next_rd_byte = rd_byte;
    next_wr_valid = (wr_s != wr_d) && !pf_s && link_rst_n;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    if (fetch_s != fetch_d)
    begin
      // pointer has been stable since the toggle moved
      next_rd_addr = ptr;
      next_rd_pend = 1'b1;
    end
    if (rd_pend)
      next_rd_byte = rd_data;
    if (wr_s != wr_d)
    begin
      next_wr_addr = wr_addr_l;
      next_wr_data = wr_data_l;
    end
  end

  always_ff @(posedge clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      fetch_d <= 1'b0;
      wr_d <= 1'b0;
      rd_pend <= 1'b0;
      rd_addr <= PTR_RESET;
      rd_byte <= BYTE_RESET;
      wr_valid <= 1'b0;
      wr_addr <= PTR_RESET;
      wr_data <= BYTE_RESET;
    end
    else
    begin
      fetch_d <= fetch_s;
      wr_d <= wr_s;
      rd_pend <= next_rd_pend;
      rd_addr <= next_rd_addr;
      rd_byte <= next_rd_byte;
      wr_valid <= next_wr_valid;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
    end
  end
endmodule

//--- rtci2c_monitor.sv
// assertion checker on the rtc serial slave ports
module rtci2c_monitor
  import rtci2c_pkg::*;
(
  // clock, reset, supply
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pwr_fail,
  // link and store
  input wire logic scl,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic wr_valid,
  input wire logic [LOC_PTR_W-1:0] wr_addr,
  input wire logic [7:0] wr_data
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ==========
  // link
  a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl)
    else $error("sda pulled in clock high");
  a_oe_fall_low: assert property (
    disable iff (!arst_n || pwr_fail) $fell(sda_oe) |-> !scl)
    else $error("sda freed in clock high");
  a_oe_steady: assert property (
    disable iff (!arst_n || pwr_fail) scl && $past(scl) |-> $stable(sda_oe))
    else $error("sda moved in clock high");
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  // ==========
  // store writes
  a_wr_acked: assert property (wr_valid |-> sda_oe)
    else $error("write without ack");
  a_wr_pulse: assert property (wr_valid |=> !wr_valid)
    else $error("write pulse too long");
  a_wr_held: assert property ($changed({wr_addr, wr_data}) |-> wr_valid)
    else $error("write bus moved alone");
  a_pf_blocked: assert property (pwr_fail [*4] |-> !wr_valid && !sda_oe)
    else $error("bus active in supply fail");
endmodule
bind rtci2c_slave rtci2c_monitor mon (.clk, .arst_n, .pwr_fail, .scl, .sda_out, .sda_oe,
  .wr_valid, .wr_addr, .wr_data);

//--- rtci2c_master.sv
// behavioural two-wire bus master; clock stands still between frames
module rtci2c_master (
  // link wires
  output logic scl,
  output logic sda_drv,
  input wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lclk;
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
    lclk = 1'b0;
    #3;
    forever #15 lclk = ~lclk;
  end
  task automatic ph();
    repeat (8) @(posedge lclk);
  endtask
  // also serves as repeated start, so data is raised while clock is low
  task automatic start();
    @(posedge lclk);
    sda_drv = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    sda_drv = 1'b0;
    ph();
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    sda_drv = 1'b1;
    ph();
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    ph();
    scl = 1'b1;
    ph();
    r = sda_in;
    scl = 1'b0;
    ph();
  endtask
  // a data byte of all ones releases the line so the slave may drive it
  task automatic xfer(input logic [7:0] tx, input logic ackb, output logic [7:0] rx,
    output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ackb, ack);
  endtask
endmodule

//--- rtc_i2c_slave_register_access_test.sv
// self-checking bench: store model, bus master and reference pointer model
module rtc_i2c_slave_register_access_test
  import rtci2c_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(n, e, s) \
  begin \
    checked++; \
    if ((s) !== (e)) \
    begin \
      fails++; \
      $display("wrong value %s exp %h got %h", n, e, s); \
    end \
  end
  logic clk, arst_n, pwr_fail, scl, sda_drv, sda, sda_oe, wr_valid, a;
  logic [LOC_PTR_W-1:0] rd_addr, wr_addr;
  logic [7:0] rd_data, wr_data, rx;
  logic [7:0] mem [8];
  logic [7:0] ref_mem [8];
  int fails, checked, cyc, ptr;
  int seed = 32'hc7e6;
  assign sda = sda_drv & ~sda_oe;
  // store answers within the cycle: the slave captures one clock after moving rd_addr
  assign rd_data = mem[rd_addr];
  rtci2c_slave dut (.clk, .arst_n, .scl, .sda_in(sda), .sda_out(), .sda_oe, .pwr_fail,
    .rd_addr, .rd_data, .wr_valid, .wr_addr, .wr_data);
  rtci2c_master m (.scl, .sda_drv, .sda_in(sda));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (wr_valid)
      mem[wr_addr] <= wr_data;
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      results();
    end
  end
  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic put(input logic [7:0] b, input logic exp);
    m.xfer(b, 1'b1, rx, a);
    `CHK("ack", exp, a)
  endtask
  task automatic wr_seq(input logic [7:0] adr, input int n);
    logic [7:0] d;
    m.start();
    put(8'hd0, 1'b0);
    put(adr, 1'b0);
    ptr = adr % 8;
    repeat (n)
    begin
      d = 8'($random(seed));
      put(d, 1'b0);
      ref_mem[ptr] = d;
      ptr = (ptr + 1) % 8;
    end
    m.stop();
  endtask
  task automatic rd_seq(input int adr, input int n);
    if (adr >= 0)
    begin
      m.start();
      put(8'hd0, 1'b0);
      put(adr[7:0], 1'b0);
      ptr = adr;
    end
    m.start();
    put(8'hd1, 1'b0);
    for (int i = 1; i <= n; i++)
    begin
      m.xfer(8'hff, i == n, rx, a);
      `CHK("read byte", ref_mem[ptr], rx)
      `CHK("master ack", i == n, a)
      if (i < n)
        ptr = (ptr + 1) % 8;
    end
    m.stop();
  endtask
  initial
  begin
    arst_n = 1'b0;
    pwr_fail = 1'b0;
    foreach (mem[i])
    begin
      mem[i] = 8'h00;
      ref_mem[i] = 8'h00;
    end
    repeat (5) @(posedge clk);
    `CHK("sda_oe in reset", 1'b0, sda_oe)
    arst_n <= 1'b1;
    repeat (12) @(posedge clk);
    wr_seq(8'h06, 4);
    rd_seq(5, 5);
    rd_seq(-1, 2);
    $display("test write and read done");
    m.start();
    put(8'hd2, 1'b1);
    put(8'h00, 1'b1);
    m.stop();
    $display("test foreign address done");
    @(posedge clk);
    pwr_fail <= 1'b1;
    repeat (10) @(posedge clk);
    m.start();
    put(8'hd0, 1'b1);
    put(8'h00, 1'b1);
    put(8'h5a, 1'b1);
    m.stop();
    @(posedge clk);
    pwr_fail <= 1'b0;
    repeat (20) @(posedge clk);
    ptr = 0;
    rd_seq(-1, 3);
    $display("test supply fail done");
    results();
  end
endmodule
